// file: src/epv_pkg.sv
// ============================================================
// shared constants for the program and verify port
package epv_pkg;

    // ============================================================
    // widths
    localparam int DATA_W = 8;
    localparam int UPPER_W = 2;
    localparam int ADDR_W = DATA_W + UPPER_W;
    localparam int MEM_DEPTH = 1 << ADDR_W;
    localparam int SYNC_STAGES = 3;

    // ============================================================
    // timing, in printed units, then in sys_clk cycles
    localparam int CLK_PERIOD_NS = 10;
    localparam int TCY_MIN_NS = 5000;
    localparam int TCY_CYC = (TCY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_TCY = 4;
    localparam int WAIT4_CYC = SETUP_TCY * TCY_CYC;
    localparam int PULSE_MIN_MS = 50;
    localparam int PULSE_MAX_MS = 60;
    localparam int NS_PER_MS = 1000000;
    localparam int PULSE_MIN_CYC = (PULSE_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_MAX_CYC = (PULSE_MAX_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int CNT_W = 23;
    localparam int DO_DELAY_CYC = 2;

    // ============================================================
    // idle pin levels seen by a freshly inserted part
    localparam logic IDLE_REG_SEL = 1'b0;
    localparam logic IDLE_DEV_SEL = 1'b1;
    localparam logic IDLE_ACCESS_HV = 1'b0;
    localparam logic IDLE_RESET = 1'b0;
    localparam logic IDLE_MODE_SEL = 1'b1;
    localparam logic IDLE_VDD_HV = 1'b0;

    // ============================================================
    // programmer sequencer states
    typedef enum logic [3:0] {
        EPV_IDLE      = 4'h0,
        EPV_MODE_LOW  = 4'h1,
        EPV_EA_UP     = 4'h2,
        EPV_ADDR      = 4'h3,
        EPV_RST_UP    = 4'h4,
        EPV_DATA      = 4'h5,
        EPV_VDD_UP    = 4'h6,
        EPV_PULSE     = 4'h7,
        EPV_PULSE_END = 4'h8,
        EPV_VDD_DOWN  = 4'h9,
        EPV_VERIFY    = 4'hA,
        EPV_MODE_LOW2 = 4'hB,
        EPV_RST_DOWN  = 4'hC,
        EPV_WAIT_NEXT = 4'hD,
        EPV_EA_DOWN   = 4'hE,
        EPV_MODE_UP   = 4'hF
    } epv_state_t;

endpackage : epv_pkg

// file: src/epv_if.sv
`timescale 1ns/100ps
// ============================================================
// socket wiring between programmer and part
interface epv_if import epv_pkg::*; ();
    logic mode_select_input;
    logic access_enable_input;
    logic reset_pin;
    logic register_select_input;
    logic dev_select;
    logic vdd_hv;
    logic prog_drv;
    logic prog_oe;
    logic [UPPER_W-1:0] upper_address_pins;
    logic [DATA_W-1:0] host_bus_out;
    logic host_bus_oe;
    logic [DATA_W-1:0] dev_bus_out;
    logic dev_bus_oe;
    logic [DATA_W-1:0] bus;
    logic prog_level;

    // resolved wire levels; a floating line reads low
    assign bus = dev_bus_oe ? dev_bus_out : (host_bus_oe ? host_bus_out : '0);
    assign prog_level = prog_oe & prog_drv;

    modport device (
        input mode_select_input,
        input access_enable_input,
        input reset_pin,
        input register_select_input,
        input dev_select,
        input vdd_hv,
        input prog_level,
        input upper_address_pins,
        input bus,
        output dev_bus_out,
        output dev_bus_oe
    );

    modport programmer (
        output mode_select_input,
        output access_enable_input,
        output reset_pin,
        output register_select_input,
        output dev_select,
        output vdd_hv,
        output prog_drv,
        output prog_oe,
        output upper_address_pins,
        output host_bus_out,
        output host_bus_oe,
        input bus
    );
endinterface : epv_if

// file: src/epv_device.sv
`timescale 1ns/100ps
// ============================================================
// part end: latches address, stores word, returns it on verify
module epv_device import epv_pkg::*; #(
    parameter int VERIFY_DELAY = DO_DELAY_CYC
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    epv_if.device pins,
    output logic [ADDR_W-1:0] latched_addr_out,
    output logic prog_active_out,
    output logic verify_active_out,
    output logic write_pulse_out
);

    localparam int SYNC_W = DATA_W + UPPER_W + 7;
    localparam int DLY_W = (VERIFY_DELAY > 1) ? $clog2(VERIFY_DELAY + 1) : 1;
    // idle socket levels, so no false pin edge follows reset
    localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'({IDLE_MODE_SEL, IDLE_ACCESS_HV,
        IDLE_RESET, 1'b0, IDLE_VDD_HV, IDLE_REG_SEL, IDLE_DEV_SEL});

    // ============================================================
    // elaboration checks
    if (VERIFY_DELAY < 1 || VERIFY_DELAY + SYNC_STAGES + 2 > WAIT4_CYC) begin : g_bad_delay
        $error("verify delay out of range");
    end

    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
    logic [DATA_W-1:0] f_bus;
    logic [UPPER_W-1:0] f_upper;
    logic f_mode, f_ea, f_rst, f_prog, f_vdd, f_regsel, f_devsel;
    logic mode_prev_q, rst_prev_q, prog_prev_q;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic [DLY_W-1:0] dly_q, dly_d;
    logic run_q, run_d, drv_q, drv_d;
    logic [DATA_W-1:0] rd_q;
    logic active, verify, start, wr_en;
    logic rst_rise, mode_rise, prog_rise, prog_fall;
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    // ============================================================
    // pin synchroniser, a change counts once stages two and three agree
    assign raw = {pins.bus, pins.upper_address_pins, pins.mode_select_input,
                  pins.access_enable_input, pins.reset_pin, pins.prog_level,
                  pins.vdd_hv, pins.register_select_input, pins.dev_select};
    assign filt_d = (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
    assign {f_bus, f_upper, f_mode, f_ea, f_rst, f_prog, f_vdd, f_regsel, f_devsel} = filt_q;

    // ============================================================
    // mode decode and edges
    always_comb begin
        active = f_ea & ~f_regsel;
        rst_rise = f_rst & ~rst_prev_q;
        mode_rise = f_mode & ~mode_prev_q;
        prog_rise = f_prog & ~prog_prev_q;
        prog_fall = ~f_prog & prog_prev_q;
        verify = active & f_mode & f_rst;
        start = verify & (mode_rise | rst_rise);
        wr_en = active & ~f_mode & f_rst & f_vdd & prog_fall;
        addr_d = (active & rst_rise) ? {f_upper, f_bus} : addr_q;
        data_d = (active & ~f_mode & prog_rise) ? f_bus : data_q;
        dly_d = dly_q;
        run_d = run_q;
        drv_d = drv_q;
        // data output delay, counted from the mode or reset rise
        if (!verify) begin
            run_d = 1'b0;
            drv_d = 1'b0;
        end else if (start) begin
            dly_d = DLY_W'(VERIFY_DELAY - 1);
            run_d = 1'b1;
            drv_d = 1'b0;
        end else if (run_q) begin
            if (dly_q == '0) begin
                run_d = 1'b0;
                drv_d = 1'b1;
            end else begin
                dly_d = dly_q - 1'b1;
            end
        end
    end

    // ============================================================
    // state registers
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s1_q <= SYNC_IDLE;
            s2_q <= SYNC_IDLE;
            s3_q <= SYNC_IDLE;
            filt_q <= SYNC_IDLE;
            mode_prev_q <= IDLE_MODE_SEL;
            rst_prev_q <= 1'b0;
            prog_prev_q <= 1'b0;
            addr_q <= '0;
            data_q <= '0;
            dly_q <= '0;
            run_q <= 1'b0;
            drv_q <= 1'b0;
            rd_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
            mode_prev_q <= f_mode;
            rst_prev_q <= f_rst;
            prog_prev_q <= f_prog;
            addr_q <= addr_d;
            data_q <= data_d;
            dly_q <= dly_d;
            run_q <= run_d;
            drv_q <= drv_d;
            rd_q <= mem[addr_q];
        end
    end

    // ============================================================
    // nonvolatile array, untouched by reset
    always_ff @(posedge sys_clk_in) begin
        if (wr_en) begin
            mem[addr_q] <= data_q;
        end
    end

    // ============================================================
    // outputs
    assign pins.dev_bus_out = rd_q;
    assign pins.dev_bus_oe = drv_q;
    assign latched_addr_out = addr_q;
    assign prog_active_out = active & ~f_mode;
    assign verify_active_out = verify;
    assign write_pulse_out = wr_en;

endmodule : epv_device

// file: src/epv_programmer.sv
`timescale 1ns/100ps
// Function
// - idle pins safe before part insertion
// - mode select low chooses program mode
// - high access enable activates program mode
// - present address on bus and upper pins
// - part latches address on reset rise
// - place data word after address latch
// - raise supply before pulse, lower after
// - one program pulse of 50 to 60 ms
// - mode select high selects verify, compare
// - part drives word within four cycles
// - delay may start from reset rise
// - next word: mode low, reset low, repeat
// - return pins to idle before removal
// - hold reset high four cycles latching
// - reset low four cycles before enable
// - instruction cycle at least 5.0 us
// - program pin floats outside program mode
// - register select low throughout
// ============================================================
// programmer end: walks the pins through the program and verify order
module epv_programmer import epv_pkg::*; #(
    parameter int PULSE_CYC = PULSE_MIN_CYC
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    epv_if.programmer pins,
    input wire logic start_in,
    input wire logic finish_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] data_in,
    output logic busy_out,
    output logic ready_out,
    output logic done_out,
    output logic verify_ok_out,
    output logic [DATA_W-1:0] read_data_out
);

    // ============================================================
    // elaboration checks
    if (PULSE_CYC < 1 || PULSE_CYC > PULSE_MAX_CYC || PULSE_CYC >= (1 << CNT_W)) begin : g_bad_pulse
        $error("pulse length out of range");
    end

    localparam logic [CNT_W-1:0] WAIT_LOAD = CNT_W'(WAIT4_CYC - 1);
    localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC - 1);

    epv_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic mode_q, mode_d, ea_q, ea_d, rst_q, rst_d, vdd_q, vdd_d;
    logic prog_q, prog_d, prog_oe_q, prog_oe_d;
    logic [DATA_W-1:0] bus_q, bus_d;
    logic [UPPER_W-1:0] upper_q, upper_d;
    logic bus_oe_q, bus_oe_d;
    logic done_q, done_d, ok_q, ok_d;
    logic [DATA_W-1:0] rd_q, rd_d;
    logic [DATA_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
    logic cnt_done;

    // ============================================================
    // read-back synchroniser on the bus
    assign filt_d = (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
    assign cnt_done = (cnt_q == '0);

    // ============================================================
    // sequencer next state and pin levels
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
        addr_d = addr_q;
        data_d = data_q;
        mode_d = mode_q;
        ea_d = ea_q;
        rst_d = rst_q;
        vdd_d = vdd_q;
        prog_d = prog_q;
        prog_oe_d = prog_oe_q;
        bus_d = bus_q;
        upper_d = upper_q;
        bus_oe_d = bus_oe_q;
        done_d = 1'b0;
        ok_d = ok_q;
        rd_d = rd_q;
        case (state_q)
            EPV_IDLE: begin
                if (start_in) begin
                    addr_d = addr_in;
                    data_d = data_in;
                    mode_d = 1'b0;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_MODE_LOW;
                end
            end
            EPV_MODE_LOW: begin
                if (cnt_done) begin
                    ea_d = 1'b1;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_EA_UP;
                end
            end
            EPV_EA_UP: begin
                if (cnt_done) begin
                    bus_d = addr_q[DATA_W-1:0];
                    upper_d = addr_q[ADDR_W-1:DATA_W];
                    bus_oe_d = 1'b1;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_ADDR;
                end
            end
            EPV_ADDR: begin
                if (cnt_done) begin
                    rst_d = 1'b1;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_RST_UP;
                end
            end
            EPV_RST_UP: begin
                if (cnt_done) begin
                    bus_d = data_q;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_DATA;
                end
            end
            EPV_DATA: begin
                if (cnt_done) begin
                    vdd_d = 1'b1;
                    prog_d = 1'b0;
                    prog_oe_d = 1'b1;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_VDD_UP;
                end
            end
            EPV_VDD_UP: begin
                if (cnt_done) begin
                    prog_d = 1'b1;
                    cnt_d = PULSE_LOAD;
                    state_d = EPV_PULSE;
                end
            end
            EPV_PULSE: begin
                if (cnt_done) begin
                    prog_d = 1'b0;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_PULSE_END;
                end
            end
            EPV_PULSE_END: begin
                if (cnt_done) begin
                    vdd_d = 1'b0;
                    prog_oe_d = 1'b0;
                    bus_oe_d = 1'b0;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_VDD_DOWN;
                end
            end
            EPV_VDD_DOWN: begin
                if (cnt_done) begin
                    mode_d = 1'b1;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_VERIFY;
                end
            end
            EPV_VERIFY: begin
                if (cnt_done) begin
                    rd_d = filt_q;
                    ok_d = (filt_q == data_q);
                    done_d = 1'b1;
                    mode_d = 1'b0;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_MODE_LOW2;
                end
            end
            EPV_MODE_LOW2: begin
                if (cnt_done) begin
                    rst_d = 1'b0;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_RST_DOWN;
                end
            end
            EPV_RST_DOWN: begin
                if (cnt_done) begin
                    state_d = EPV_WAIT_NEXT;
                end
            end
            EPV_WAIT_NEXT: begin
                if (start_in) begin
                    addr_d = addr_in;
                    data_d = data_in;
                    bus_d = addr_in[DATA_W-1:0];
                    upper_d = addr_in[ADDR_W-1:DATA_W];
                    bus_oe_d = 1'b1;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_ADDR;
                end else if (finish_in) begin
                    ea_d = IDLE_ACCESS_HV;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_EA_DOWN;
                end
            end
            EPV_EA_DOWN: begin
                if (cnt_done) begin
                    mode_d = IDLE_MODE_SEL;
                    cnt_d = WAIT_LOAD;
                    state_d = EPV_MODE_UP;
                end
            end
            EPV_MODE_UP: begin
                if (cnt_done) begin
                    state_d = EPV_IDLE;
                end
            end
            default: begin
                state_d = EPV_IDLE;
            end
        endcase
    end

    // ============================================================
    // sequencer registers, reset to the idle socket levels
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= EPV_IDLE;
            cnt_q <= '0;
            addr_q <= '0;
            data_q <= '0;
            mode_q <= IDLE_MODE_SEL;
            ea_q <= IDLE_ACCESS_HV;
            rst_q <= IDLE_RESET;
            vdd_q <= IDLE_VDD_HV;
            prog_q <= 1'b0;
            prog_oe_q <= 1'b0;
            bus_q <= '0;
            upper_q <= '0;
            bus_oe_q <= 1'b0;
            done_q <= 1'b0;
            ok_q <= 1'b0;
            rd_q <= '0;
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            data_q <= data_d;
            mode_q <= mode_d;
            ea_q <= ea_d;
            rst_q <= rst_d;
            vdd_q <= vdd_d;
            prog_q <= prog_d;
            prog_oe_q <= prog_oe_d;
            bus_q <= bus_d;
            upper_q <= upper_d;
            bus_oe_q <= bus_oe_d;
            done_q <= done_d;
            ok_q <= ok_d;
            rd_q <= rd_d;
            s1_q <= pins.bus;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end

    // ============================================================
    // pin and user outputs
    assign pins.mode_select_input = mode_q;
    assign pins.access_enable_input = ea_q;
    assign pins.reset_pin = rst_q;
    assign pins.register_select_input = IDLE_REG_SEL;
    assign pins.dev_select = IDLE_DEV_SEL;
    assign pins.vdd_hv = vdd_q;
    assign pins.prog_drv = prog_q;
    assign pins.prog_oe = prog_oe_q;
    assign pins.upper_address_pins = upper_q;
    assign pins.host_bus_out = bus_q;
    assign pins.host_bus_oe = bus_oe_q;
    assign busy_out = (state_q != EPV_IDLE) && (state_q != EPV_WAIT_NEXT);
    assign ready_out = (state_q == EPV_IDLE) || (state_q == EPV_WAIT_NEXT);
    assign done_out = done_q;
    assign verify_ok_out = ok_q;
    assign read_data_out = rd_q;

endmodule : epv_programmer

// file: bench/epv_assertions.sv
`timescale 1ns/100ps
// ============================================================
// socket checks between programmer and part
module epv_assertions import epv_pkg::*; #(
    parameter int PULSE_CYC = PULSE_MIN_CYC
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic mode_select_input,
    input wire logic access_enable_input,
    input wire logic reset_pin,
    input wire logic register_select_input,
    input wire logic vdd_hv,
    input wire logic prog_oe,
    input wire logic prog_level,
    input wire logic host_bus_oe,
    input wire logic dev_bus_oe
);
    logic rst_prev_q, rst_prev_d;
    logic [15:0] ver_cnt_q, ver_cnt_d;
    logic [15:0] lvl_cnt_q, lvl_cnt_d;
    logic [22:0] pw_cnt_q, pw_cnt_d;

    // cycles since the reset pin last moved, and length of the pulse
    always_comb begin
        rst_prev_d = reset_pin;
        lvl_cnt_d = lvl_cnt_q;
        if (reset_pin != rst_prev_q) begin
            lvl_cnt_d = 16'h0000;
        end else if (lvl_cnt_q != 16'hFFFF) begin
            lvl_cnt_d = lvl_cnt_q + 16'h0001;
        end
        pw_cnt_d = prog_level ? pw_cnt_q + 23'h000001 : 23'h000000;
        // cycles spent in verify mode while the part still floats the bus
        ver_cnt_d = (mode_select_input && access_enable_input && reset_pin && !dev_bus_oe)
            ? ver_cnt_q + 16'h0001 : 16'h0000;
    end

    // registers of the helper counters
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rst_prev_q <= 1'b0;
            lvl_cnt_q <= 16'h0000;
            pw_cnt_q <= 23'h000000;
            ver_cnt_q <= 16'h0000;
        end else begin
            rst_prev_q <= rst_prev_d;
            lvl_cnt_q <= lvl_cnt_d;
            pw_cnt_q <= pw_cnt_d;
            ver_cnt_q <= ver_cnt_d;
        end
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    // ============================================================
    // pin order and timing
    a_mode_first: assert property ($rose(access_enable_input) |-> !mode_select_input)
        else $error("enable raised while mode select high");
    a_reset_settled: assert property ($rose(access_enable_input)
        |-> !reset_pin && lvl_cnt_q >= 16'(WAIT4_CYC - 2))
        else $error("reset not low long enough before enable");
    a_latch_hold: assert property ($fell(reset_pin) |-> lvl_cnt_q >= 16'(WAIT4_CYC - 2))
        else $error("reset high too short");
    a_verify_delay: assert property (ver_cnt_q < 16'(WAIT4_CYC))
        else $error("verify data late");
    a_verify_seen: assert property ($fell(mode_select_input) && access_enable_input
        && reset_pin |-> $past(dev_bus_oe))
        else $error("verify ended before data out");
    a_bus_owner: assert property (dev_bus_oe |-> access_enable_input && reset_pin
        && !register_select_input && !host_bus_oe)
        else $error("part drives bus outside verify");
    a_pulse_float: assert property (prog_oe |-> access_enable_input && !mode_select_input)
        else $error("pulse pin driven outside program mode");
    a_supply_up: assert property ($rose(prog_level) |-> vdd_hv)
        else $error("pulse without supply");
    a_supply_down: assert property ($fell(vdd_hv) |-> !prog_level)
        else $error("supply lowered during pulse");
    a_pulse_width: assert property ($fell(prog_level) |-> pw_cnt_q == 23'(PULSE_CYC))
        else $error("pulse width wrong");
    a_regsel_low: assert property (access_enable_input |-> !register_select_input)
        else $error("register select high in program mode");

    // main scenarios seen
    c_verify: cover property ($rose(dev_bus_oe));
    c_pulse: cover property ($fell(prog_level));
    c_leave: cover property ($fell(access_enable_input));
endmodule : epv_assertions

// file: bench/tb_eprom_program_verify_port.sv
`timescale 1ns/100ps
// ============================================================
// bench: program words through the socket and read them back
module tb_eprom_program_verify_port import epv_pkg::*;;
    localparam int PULSE = 20;
    localparam int WAIT_LIM = 30000;
    logic sys_clk_in, sys_rst_in, start_in, finish_in;
    logic [ADDR_W-1:0] addr_in, a0;
    logic [DATA_W-1:0] data_in, read_data_out;
    logic busy_out, ready_out, done_out, verify_ok_out;
    logic [ADDR_W-1:0] latched_addr_out;
    logic prog_active_out, verify_active_out, write_pulse_out;
    int err_total, total_checks, wr_seen, rnd;
    logic [DATA_W-1:0] mem_model [int];

    epv_if i_epv_if ();
    epv_device i_epv_device (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .pins(i_epv_if.device), .latched_addr_out(latched_addr_out),
        .prog_active_out(prog_active_out), .verify_active_out(verify_active_out),
        .write_pulse_out(write_pulse_out));
    epv_programmer #(.PULSE_CYC(PULSE)) i_epv_programmer (.sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in), .pins(i_epv_if.programmer), .start_in(start_in),
        .finish_in(finish_in), .addr_in(addr_in), .data_in(data_in), .busy_out(busy_out),
        .ready_out(ready_out), .done_out(done_out), .verify_ok_out(verify_ok_out),
        .read_data_out(read_data_out));
    epv_assertions #(.PULSE_CYC(PULSE)) i_epv_assertions (.sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in), .mode_select_input(i_epv_if.mode_select_input),
        .access_enable_input(i_epv_if.access_enable_input), .reset_pin(i_epv_if.reset_pin),
        .register_select_input(i_epv_if.register_select_input), .vdd_hv(i_epv_if.vdd_hv),
        .prog_oe(i_epv_if.prog_oe), .prog_level(i_epv_if.prog_level),
        .host_bus_oe(i_epv_if.host_bus_oe), .dev_bus_oe(i_epv_if.dev_bus_oe));

    // 100 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // count stored words
    always @(posedge sys_clk_in) begin
        if (write_pulse_out === 1'b1) wr_seen++;
    end

    // ============================================================
    // helpers
    task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check_val

    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // one-cycle request on the user side
    task automatic go(input logic s, input logic f, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        @(posedge sys_clk_in);
        #1;
        start_in = s;
        finish_in = f;
        addr_in = a;
        data_in = d;
        @(posedge sys_clk_in);
        #1;
        start_in = 1'b0;
        finish_in = 1'b0;
    endtask : go

    task automatic wait_ready;
        int n;
        n = 0;
        while (ready_out !== 1'b1 && n < WAIT_LIM) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        check_val(32'(ready_out), 32'h1);
    endtask : wait_ready

    // socket pins against the idle levels of an unused socket
    task automatic check_idle;
        logic [8:0] seen;
        seen = {i_epv_if.mode_select_input, i_epv_if.access_enable_input, i_epv_if.reset_pin,
            i_epv_if.vdd_hv, i_epv_if.register_select_input, i_epv_if.dev_select,
            i_epv_if.prog_oe, i_epv_if.host_bus_oe, i_epv_if.dev_bus_oe};
        check_val(32'(seen), 32'({IDLE_MODE_SEL, IDLE_ACCESS_HV, IDLE_RESET, IDLE_VDD_HV,
            IDLE_REG_SEL, IDLE_DEV_SEL, 3'h0}));
        $display("idle test done");
    endtask : check_idle

    // program one word, try a refused request meanwhile, verify the answer
    task automatic program_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n, w0;
        wait_ready();
        w0 = wr_seen;
        go(1'b1, 1'b0, a, d);
        mem_model[a] = d;
        go(1'b1, 1'b1, ~a, ~d);
        n = 0;
        while (done_out !== 1'b1 && n < WAIT_LIM) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        check_val(32'(read_data_out), 32'(mem_model[a]));
        check_val(32'(verify_ok_out), 32'h1);
        check_val(32'(i_epv_if.bus), 32'(mem_model[a]));
        check_val(32'(latched_addr_out), 32'(a));
        check_val(32'({busy_out, prog_active_out, verify_active_out}), 32'h5);
        check_val(32'(wr_seen - w0), 32'h1);
        $display("word test done at %0h", a);
    endtask : program_word

    // ============================================================
    // main sequence
    initial begin
        sys_rst_in = 1'b1;
        start_in = 1'b0;
        finish_in = 1'b0;
        addr_in = '0;
        data_in = '0;
        err_total = 0;
        total_checks = 0;
        wr_seen = 0;
        repeat (16) @(posedge sys_clk_in);
        #1;
        sys_rst_in = 1'b0;
        rnd = $urandom(84);
        check_idle();
        a0 = ADDR_W'($urandom_range(1022, 1));
        program_word(a0, DATA_W'($urandom));
        program_word(10'h3FF, DATA_W'($urandom));
        wait_ready();
        check_val(32'(prog_active_out), 32'h1);
        go(1'b0, 1'b1, '0, '0);
        wait_ready();
        check_idle();
        program_word(a0, DATA_W'($urandom));
        give_verdict();
    end

    // watchdog against a hung sequence
    initial begin
        repeat (90000) @(posedge sys_clk_in);
        err_total++;
        $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, 0, 1);
        give_verdict();
    end
endmodule : tb_eprom_program_verify_port
